// file: bench/fwsr_flash_model.sv
// Behavioural flash device answering command writes and status polls
`timescale 1ns/1ps
module fwsr_flash_model #(
    parameter WIN = 60,
    parameter LEN = 3
) (
    input wire clk_i,
    input wire [15:0] hdq_i,
    input wire dq_oe_n_i,
    input wire ce_n_i,
    input wire oe_n_i,
    input wire we_n_i,
    input wire [1:0] fail_i,
    output wire [15:0] dq_o,
    output wire ready_busy_n_o
);
    reg [1:0] op_q = 2'h0;
    reg arm_q = 1'b0;
    reg tog_q = 1'b0;
    reg we_q = 1'b1;
    reg ce_q = 1'b1;
    reg oe_q = 1'b1;
    reg [15:0] d_q = 16'h0000;
    reg [15:0] tgt_q = 16'h0000;
    reg [15:0] mem_q = 16'hffff;
    reg [15:0] rd_q = 16'h0000;
    reg [7:0] wcnt_q = 8'h00;
    reg [3:0] left_q = 4'h0;

    // Wire level: host data, device data, or the inverse of the last read once released
    assign dq_o = !dq_oe_n_i ? hdq_i : (!ce_n_i && !oe_n_i) ? rd_q : ~rd_q;
    assign ready_busy_n_o = (op_q == 2'h0);

    // Pin edges seen on the clock, since pins move only on clock edges
    always @(posedge clk_i) begin
        we_q <= we_n_i;
        ce_q <= ce_n_i;
        oe_q <= oe_n_i;
        if (!we_n_i)
            d_q <= hdq_i;
        if (wcnt_q != 8'h00)
            wcnt_q <= wcnt_q - 8'h01;
        if (we_n_i && !we_q && !ce_q) begin
            if (d_q == 16'h00f0 && op_q != 2'h2) begin
                op_q <= 2'h0;
                arm_q <= 1'b0;
            end else if (op_q == 2'h2) begin
                if (wcnt_q != 8'h00 && d_q == 16'h0030)
                    wcnt_q <= WIN;
            end else if (op_q == 2'h0) begin
                if (arm_q) begin
                    op_q <= 2'h1;
                    tgt_q <= d_q;
                    left_q <= LEN;
                    arm_q <= 1'b0;
                end else if (d_q == 16'h00a0) begin
                    arm_q <= 1'b1;
                end else if (d_q == 16'h0030 || d_q == 16'h0010) begin
                    op_q <= 2'h2;
                    left_q <= LEN;
                    wcnt_q <= (d_q == 16'h0030) ? WIN : 8'h00;
                end
            end
        end
        // Status replaces array data while busy
        if (!oe_n_i && oe_q && !ce_n_i) begin
            if (op_q == 2'h0) begin
                rd_q <= mem_q;
            end else begin
                tog_q <= ~tog_q;
                if (op_q == 2'h1)
                    rd_q <= {8'h00, ~tgt_q[7], tog_q, fail_i == 2'h1, 3'h0,
                             fail_i == 2'h2, 1'b0};
                else
                    rd_q <= {8'h00, 1'b0, tog_q, 1'b0, 1'b0, wcnt_q == 8'h00,
                             tog_q, 2'h0};
                if (fail_i == 2'h0 && (op_q == 2'h1 || wcnt_q == 8'h00)) begin
                    left_q <= left_q - 4'h1;
                    if (left_q == 4'h1) begin
                        op_q <= 2'h0;
                        mem_q <= (op_q == 2'h1) ? tgt_q : 16'hffff;
                    end
                end
            end
        end
    end
endmodule // fwsr_flash_model

// file: bench/fwsr_host_monitor.sv
// Checker on the pin and user ports of the flash write status host
`timescale 1ns/1ps
module fwsr_host_monitor (
    input wire clk_i,
    input wire rst_n_i,
    input wire cmd_valid_i,
    input wire ready_busy_n_i,
    input wire [20:0] addr_o,
    input wire dq_oe_n_o,
    input wire ce_n_o,
    input wire oe_n_o,
    input wire we_n_o,
    input wire busy_o,
    input wire done_o,
    input wire device_ready_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Pin strobes: a fight on the data lines would corrupt status
    chk_strobe_excl: assert property (we_n_o || oe_n_o)
        else $error("write and read strobes overlap");
    chk_strobe_select: assert property (!we_n_o || !oe_n_o |-> !ce_n_o)
        else $error("strobe without chip select");
    chk_write_drive: assert property (!we_n_o |-> !dq_oe_n_o)
        else $error("write strobe with data lines released");
    chk_read_release: assert property (!oe_n_o |-> dq_oe_n_o)
        else $error("host drives data lines during a read");
    chk_we_width: assert property ($fell(we_n_o) |-> !we_n_o [*2] ##1 we_n_o)
        else $error("write strobe width wrong");
    chk_oe_width: assert property ($fell(oe_n_o) |-> !oe_n_o [*5] ##1 oe_n_o)
        else $error("read strobe width wrong");
    chk_addr_hold: assert property (!ce_n_o && !$past(ce_n_o) |-> $stable(addr_o))
        else $error("address moved inside a bus cycle");

    // User side handshake
    chk_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    chk_cmd_take: assert property (cmd_valid_i && !busy_o && !done_o |=> busy_o)
        else $error("idle host did not take command");
    chk_ready_follow: assert property ($past(rst_n_i) |-> device_ready_o == $past(ready_busy_n_i))
        else $error("ready report not one flop behind pin");
endmodule // fwsr_host_monitor

// file: bench/tb_top.sv
// Self-checking bench for the flash write status host
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic [2:0] cmd_i = 3'h0;
    logic [20:0] cmd_addr_i = 21'h000000;
    logic [15:0] cmd_data_i = 16'h0000;
    logic [1:0] fail_mode = 2'h0;
    wire [20:0] addr_o;
    wire [15:0] dq_o, dq_i, status_o;
    wire [1:0] result_o;
    wire dq_oe_n_o, ce_n_o, oe_n_o, we_n_o, busy_o, done_o;
    wire erase_window_o, device_ready_o, ready_busy_n_i;
    int fails = 0;
    int checked = 0;
    int cyc = 0;

    always #10 clk_i = ~clk_i;

    fwsr_host #(.WIN_CYC(40)) i_fwsr_host (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_addr_i(cmd_addr_i),
        .cmd_data_i(cmd_data_i), .dq_i(dq_i), .ready_busy_n_i(ready_busy_n_i),
        .addr_o(addr_o), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .ce_n_o(ce_n_o),
        .oe_n_o(oe_n_o), .we_n_o(we_n_o), .busy_o(busy_o), .done_o(done_o),
        .result_o(result_o), .erase_window_o(erase_window_o),
        .status_o(status_o), .device_ready_o(device_ready_o));

    // Device window is longer than the host's, so skipped checks stay safe
    fwsr_flash_model #(.WIN(60), .LEN(3)) i_fwsr_flash_model (.clk_i(clk_i),
        .hdq_i(dq_o), .dq_oe_n_i(dq_oe_n_o), .ce_n_i(ce_n_o), .oe_n_i(oe_n_o),
        .we_n_i(we_n_o), .fail_i(fail_mode), .dq_o(dq_i),
        .ready_busy_n_o(ready_busy_n_i));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One user command, waiting for done under a bounded count
    task automatic run(input logic [2:0] c, input logic [20:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        #2;
        cmd_i = c;
        cmd_addr_i = a;
        cmd_data_i = d;
        cmd_valid_i = 1'b1;
        @(posedge clk_i);
        #2;
        cmd_valid_i = 1'b0;
        while (done_o !== 1'b1 && n < 5000) begin
            @(posedge clk_i);
            #2;
            n++;
        end
        if (n == 5000) begin
            fails++;
            tally_and_finish;
        end
    endtask

    task automatic prog_raw(input logic [15:0] d);
        run(3'h0, 21'h000555, 16'h00aa);
        run(3'h0, 21'h0002aa, 16'h0055);
        run(3'h0, 21'h000555, 16'h00a0);
        run(3'h0, 21'h000140, d);
    endtask

    task automatic tally_and_finish;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Hang guard well beyond the expected run
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (20) @(posedge clk_i);
        #2;
        rst_n_i = 1'b1;
        run(3'h1, 21'h000100, 16'h005a);
        check({14'h0, result_o}, 16'h0000);
        check({15'h0, status_o[7]}, 16'h0000);
        check({15'h0, device_ready_o}, 16'h0001);
        fail_mode = 2'h1;
        run(3'h1, 21'h000104, 16'h0081);
        check({14'h0, result_o}, 16'h0001);
        fail_mode = 2'h2;
        prog_raw(16'h0033);
        run(3'h6, 21'h000140, 16'h0033);
        check({14'h0, result_o}, 16'h0002);
        fail_mode = 2'h0;
        prog_raw(16'h00c3);
        run(3'h6, 21'h000140, 16'h00c3);
        check({14'h0, result_o}, 16'h0000);
        run(3'h2, 21'h010000, 16'h0000);
        check({15'h0, erase_window_o}, 16'h0000);
        check({15'h0, device_ready_o}, 16'h0000);
        run(3'h3, 21'h020000, 16'h0000);
        check({14'h0, result_o}, 16'h0000);
        repeat (80) @(posedge clk_i);
        run(3'h3, 21'h030000, 16'h0000);
        check({14'h0, result_o}, 16'h0003);
        check({15'h0, erase_window_o}, 16'h0001);
        run(3'h5, 21'h010000, 16'h0000);
        check({14'h0, result_o}, 16'h0000);
        check({15'h0, device_ready_o}, 16'h0001);
        run(3'h4, 21'h000555, 16'h0000);
        check({14'h0, result_o}, 16'h0000);
        run(3'h7, 21'h000555, 16'h0000);
        check({14'h0, result_o}, 16'h0000);
        tally_and_finish;
    end
endmodule // tb_top

bind fwsr_host fwsr_host_monitor i_fwsr_host_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i), .ready_busy_n_i(ready_busy_n_i), .addr_o(addr_o),
    .dq_oe_n_o(dq_oe_n_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
    .busy_o(busy_o), .done_o(done_o), .device_ready_o(device_ready_o));

// file: core/fwsr_cycle.v
// One read or write cycle on the flash pins, with setup, strobe and recovery phases
`timescale 1ns/1ps
module fwsr_cycle #(
    parameter AW = 21,
    parameter DW = 16,
    parameter RD_CYC = 5,
    parameter WR_CYC = 2,
    parameter REC_CYC = 2
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire start_i,
    input wire wr_i,
    input wire [AW-1:0] addr_i,
    input wire [DW-1:0] data_i,
    input wire [DW-1:0] dq_i,
    output reg [AW-1:0] addr_o,
    output reg [DW-1:0] dq_o,
    output reg dq_oe_n_o,
    output reg ce_n_o,
    output reg oe_n_o,
    output reg we_n_o,
    output reg [DW-1:0] rd_data_o,
    output reg done_o
);
    localparam [3:0] RD_N = RD_CYC[3:0] - 4'h1;
    localparam [3:0] WR_N = WR_CYC[3:0] - 4'h1;
    localparam [3:0] REC_N = REC_CYC[3:0] - 4'h1;
    localparam [2:0] P_SET = 3'h1;
    localparam [2:0] P_STB = 3'h2;
    localparam [2:0] P_REC = 3'h4;

    reg busy_q;
    reg wr_q;
    reg [2:0] ph_q;
    reg [3:0] cnt_q;

    // Address settles one cycle before the strobe falls, so the device latches it cleanly
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_q <= 1'b0;
            wr_q <= 1'b0;
            ph_q <= P_SET;
            cnt_q <= 4'h0;
            addr_o <= {AW{1'b0}};
            dq_o <= {DW{1'b0}};
            dq_oe_n_o <= 1'b1;
            ce_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            we_n_o <= 1'b1;
            rd_data_o <= {DW{1'b0}};
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (!busy_q) begin
                if (start_i) begin
                    busy_q <= 1'b1;
                    wr_q <= wr_i;
                    ph_q <= P_SET;
                    addr_o <= addr_i;
                    dq_o <= data_i;
                    dq_oe_n_o <= ~wr_i; // Low while we drive
                    ce_n_o <= 1'b0;
                end
            end else begin
                case (ph_q)
                    P_SET: begin
                        oe_n_o <= wr_q;
                        we_n_o <= ~wr_q;
                        cnt_q <= wr_q ? WR_N : RD_N;
                        ph_q <= P_STB;
                    end
                    P_STB: begin
                        if (cnt_q == 4'h0) begin
                            // Sample just before releasing the strobe, after access time
                            if (!wr_q) begin
                                rd_data_o <= dq_i;
                            end
                            oe_n_o <= 1'b1;
                            we_n_o <= 1'b1;
                            ce_n_o <= 1'b1;
                            cnt_q <= REC_N;
                            ph_q <= P_REC;
                        end else begin
                            cnt_q <= cnt_q - 4'h1;
                        end
                    end
                    P_REC: begin
                        if (cnt_q == 4'h0) begin
                            busy_q <= 1'b0;
                            dq_oe_n_o <= 1'b1;
                            done_o <= 1'b1;
                        end else begin
                            cnt_q <= cnt_q - 4'h1;
                        end
                    end
                    default: begin
                        ph_q <= P_SET;
                        busy_q <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // fwsr_cycle

// file: core/fwsr_host.v
// Host controller that issues flash command sequences and tracks write/erase status
`timescale 1ns/1ps
`include "fwsr_map.vh"

module fwsr_host #(
    parameter AW = 21,
    parameter DW = 16,
    parameter WIN_CYC = `FWSR_WIN_CYC
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire cmd_valid_i,
    input wire [2:0] cmd_i,
    input wire [AW-1:0] cmd_addr_i,
    input wire [DW-1:0] cmd_data_i,
    input wire [DW-1:0] dq_i,
    input wire ready_busy_n_i,
    output wire [AW-1:0] addr_o,
    output wire [DW-1:0] dq_o,
    output wire dq_oe_n_o,
    output wire ce_n_o,
    output wire oe_n_o,
    output wire we_n_o,
    output reg busy_o,
    output reg done_o,
    output reg [1:0] result_o,
    output reg erase_window_o,
    output reg [DW-1:0] status_o,
    output reg device_ready_o
);
    localparam [7:0] S_IDLE = 8'h01;
    localparam [7:0] S_PRE = 8'h02;
    localparam [7:0] S_SEQ = 8'h04;
    localparam [7:0] S_TGL = 8'h08;
    localparam [7:0] S_DPL = 8'h10;
    localparam [7:0] S_WIN = 8'h20;
    localparam [7:0] S_POST = 8'h40;
    localparam [7:0] S_DONE = 8'h80;
    localparam [15:0] WIN_N = WIN_CYC[15:0];

    reg [7:0] st_q;
    reg [3:0] kind_q;
    reg [2:0] step_q;
    reg [AW-1:0] addr_q;
    reg [DW-1:0] data_q;
    reg pend_q;
    reg go_q;
    reg wr_q;
    reg [AW-1:0] cyc_addr_q;
    reg [DW-1:0] cyc_data_q;
    reg first_q;
    reg chk_q;
    reg acc_q;
    reg [DW-1:0] prev_q;
    reg [15:0] gap_q;
    wire [DW-1:0] rd_data;
    wire cyc_done;

    // Sequence word tables, indexed by kind and step
    function [AW-1:0] seq_addr;
        input [3:0] kind;
        input [2:0] step;
        input [AW-1:0] a;
        begin
            if (kind == {1'b0, `FWSR_CMD_RAW} || kind == {1'b0, `FWSR_CMD_ADD} ||
                kind == {1'b0, `FWSR_CMD_RESET}) begin
                seq_addr = a;
            end else if (step == 3'h1 || step == 3'h4) begin
                seq_addr = `FWSR_ADR_UNLOCK2;
            end else if ((kind == {1'b0, `FWSR_CMD_PROG} && step == 3'h3) ||
                         (kind == {1'b0, `FWSR_CMD_SECTOR} && step == 3'h5)) begin
                seq_addr = a;
            end else begin
                seq_addr = `FWSR_ADR_UNLOCK1;
            end
        end
    endfunction

    function [DW-1:0] seq_data;
        input [3:0] kind;
        input [2:0] step;
        input [DW-1:0] d;
        begin
            case (step)
                3'h0: seq_data = (kind == {1'b0, `FWSR_CMD_RAW}) ? d :
                                 (kind == {1'b0, `FWSR_CMD_ADD}) ? `FWSR_DAT_SECTOR :
                                 (kind == {1'b0, `FWSR_CMD_RESET}) ? `FWSR_DAT_RESET :
                                 `FWSR_DAT_UNLOCK1;
                3'h1: seq_data = `FWSR_DAT_UNLOCK2;
                3'h2: seq_data = (kind == {1'b0, `FWSR_CMD_PROG}) ? `FWSR_DAT_PROG :
                                 (kind == `FWSR_KIND_REC) ? `FWSR_DAT_RESET :
                                 `FWSR_DAT_ERASE;
                3'h3: seq_data = (kind == {1'b0, `FWSR_CMD_PROG}) ? d : `FWSR_DAT_UNLOCK1;
                3'h4: seq_data = `FWSR_DAT_UNLOCK2;
                default: seq_data = (kind == {1'b0, `FWSR_CMD_CHIP}) ? `FWSR_DAT_CHIP :
                                    `FWSR_DAT_SECTOR;
            endcase
        end
    endfunction

    function [2:0] seq_last;
        input [3:0] kind;
        begin
            case (kind)
                {1'b0, `FWSR_CMD_PROG}: seq_last = 3'h3;
                {1'b0, `FWSR_CMD_SECTOR}: seq_last = 3'h5;
                {1'b0, `FWSR_CMD_CHIP}: seq_last = 3'h5;
                `FWSR_KIND_REC: seq_last = 3'h2;
                default: seq_last = 3'h0;
            endcase
        end
    endfunction

    fwsr_cycle #(
        .AW(AW),
        .DW(DW),
        .RD_CYC(`FWSR_TACC_CYC),
        .WR_CYC(`FWSR_TWP_CYC),
        .REC_CYC(`FWSR_TREC_CYC)
    ) u_cycle (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_i(go_q),
        .wr_i(wr_q),
        .addr_i(cyc_addr_q),
        .data_i(cyc_data_q),
        .dq_i(dq_i),
        .addr_o(addr_o),
        .dq_o(dq_o),
        .dq_oe_n_o(dq_oe_n_o),
        .ce_n_o(ce_n_o),
        .oe_n_o(oe_n_o),
        .we_n_o(we_n_o),
        .rd_data_o(rd_data),
        .done_o(cyc_done)
    );

    // Time since the last sector erase word, saturating at the window length
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_q <= WIN_N;
        end else if (st_q == S_SEQ && cyc_done && step_q == seq_last(kind_q) &&
                     (kind_q == {1'b0, `FWSR_CMD_SECTOR} ||
                      kind_q == {1'b0, `FWSR_CMD_ADD})) begin
            gap_q <= 16'h0000;
        end else if (gap_q != WIN_N) begin
            gap_q <= gap_q + 16'h0001;
        end
    end

    // Main sequencer; every state except S_IDLE and S_DONE launches one bus cycle and acts on its completion
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= S_IDLE;
            kind_q <= 4'h0;
            step_q <= 3'h0;
            addr_q <= {AW{1'b0}};
            data_q <= {DW{1'b0}};
            pend_q <= 1'b0;
            go_q <= 1'b0;
            wr_q <= 1'b0;
            cyc_addr_q <= {AW{1'b0}};
            cyc_data_q <= {DW{1'b0}};
            first_q <= 1'b1;
            chk_q <= 1'b0;
            acc_q <= 1'b0;
            prev_q <= {DW{1'b0}};
            busy_o <= 1'b0;
            done_o <= 1'b0;
            result_o <= `FWSR_RES_OK;
            erase_window_o <= 1'b0;
            status_o <= {DW{1'b0}};
            device_ready_o <= 1'b0;
        end else begin
            go_q <= 1'b0;
            done_o <= 1'b0;
            device_ready_o <= ready_busy_n_i;
            if (cyc_done) begin
                pend_q <= 1'b0;
            end
            if (!pend_q && st_q != S_IDLE && st_q != S_DONE) begin
                go_q <= 1'b1;
                pend_q <= 1'b1;
                wr_q <= (st_q == S_SEQ);
                // Status reads go to the command address: the sector or last loaded word
                cyc_addr_q <= (st_q == S_SEQ) ? seq_addr(kind_q, step_q, addr_q) :
                              addr_q;
                cyc_data_q <= seq_data(kind_q, step_q, data_q);
            end
            if (cyc_done && st_q != S_SEQ) begin
                status_o <= rd_data;
            end
            case (st_q)
                S_IDLE: begin
                    if (cmd_valid_i) begin
                        busy_o <= 1'b1;
                        kind_q <= {1'b0, cmd_i};
                        addr_q <= cmd_addr_i;
                        data_q <= cmd_data_i;
                        step_q <= 3'h0;
                        first_q <= 1'b1;
                        chk_q <= 1'b0;
                        acc_q <= (cmd_i == `FWSR_CMD_SECTOR);
                        result_o <= `FWSR_RES_OK;
                        if (cmd_i == `FWSR_CMD_WAIT) begin
                            st_q <= S_TGL;
                        end else if (cmd_i == `FWSR_CMD_POLLBUF) begin
                            st_q <= S_DPL;
                        end else if (cmd_i == `FWSR_CMD_ADD && gap_q == WIN_N) begin
                            st_q <= S_PRE;
                        end else begin
                            st_q <= S_SEQ; // Close spacing skips the flag
                        end
                    end
                end
                S_PRE: begin
                    if (cyc_done) begin
                        erase_window_o <= rd_data[`FWSR_ERASE_WINDOW_FLAG];
                        if (rd_data[`FWSR_ERASE_WINDOW_FLAG]) begin
                            result_o <= `FWSR_RES_REJECT; // Erase already running
                            st_q <= S_DONE;
                        end else begin
                            st_q <= S_SEQ;
                        end
                    end
                end
                S_SEQ: begin
                    if (cyc_done) begin
                        step_q <= step_q + 3'h1;
                        if (step_q == seq_last(kind_q)) begin
                            step_q <= 3'h0;
                            first_q <= 1'b1;
                            chk_q <= 1'b0;
                            case (kind_q)
                                {1'b0, `FWSR_CMD_PROG}: st_q <= S_DPL;
                                {1'b0, `FWSR_CMD_SECTOR}: st_q <= S_TGL;
                                {1'b0, `FWSR_CMD_CHIP}: st_q <= S_TGL;
                                {1'b0, `FWSR_CMD_ADD}: st_q <= (gap_q == WIN_N) ? S_POST :
                                                               S_DONE;
                                default: st_q <= S_DONE;
                            endcase
                        end
                    end
                end
                S_TGL: begin
                    if (cyc_done) begin
                        prev_q <= rd_data;
                        first_q <= 1'b0;
                        if (!first_q) begin
                            if (acc_q) begin
                                // Second read after the sector erase, toggle bit not compared: now look at the window
                                st_q <= S_WIN;
                            end else if (prev_q[`FWSR_FIRST_TOGGLE_BIT] ==
                                         rd_data[`FWSR_FIRST_TOGGLE_BIT]) begin
                                st_q <= S_DONE;
                            end else if (chk_q) begin
                                result_o <= `FWSR_RES_TIMEOUT;
                                kind_q <= {1'b0, `FWSR_CMD_RESET};
                                st_q <= S_SEQ;
                            end else if (rd_data[`FWSR_TIMEOUT_FAILURE_FLAG]) begin
                                // Toggle may stop just as the flag rises: check once more
                                chk_q <= 1'b1;
                                first_q <= 1'b1;
                            end
                        end
                    end
                end
                S_DPL: begin
                    if (cyc_done) begin
                        if (rd_data[`FWSR_POLLING_BIT] == data_q[`FWSR_POLLING_BIT]) begin
                            st_q <= S_DONE;
                        end else if (chk_q) begin
                            result_o <= `FWSR_RES_TIMEOUT;
                            kind_q <= {1'b0, `FWSR_CMD_RESET};
                            st_q <= S_SEQ;
                        end else if (rd_data[`FWSR_BUFFER_ABORT_FLAG]) begin
                            result_o <= `FWSR_RES_ABORT;
                            kind_q <= `FWSR_KIND_REC;
                            st_q <= S_SEQ;
                        end else if (rd_data[`FWSR_TIMEOUT_FAILURE_FLAG]) begin
                            chk_q <= 1'b1; // Polling bit may flip with the flag
                        end
                    end
                end
                S_WIN: begin
                    if (cyc_done) begin
                        erase_window_o <= rd_data[`FWSR_ERASE_WINDOW_FLAG];
                        st_q <= S_DONE;
                    end
                end
                S_POST: begin
                    if (cyc_done) begin
                        erase_window_o <= rd_data[`FWSR_ERASE_WINDOW_FLAG];
                        if (rd_data[`FWSR_ERASE_WINDOW_FLAG]) begin
                            result_o <= `FWSR_RES_REJECT; // Added sector may be lost
                        end
                        st_q <= S_DONE;
                    end
                end
                S_DONE: begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    st_q <= S_IDLE;
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule // fwsr_host

// file: core/fwsr_map.vh
// Constants for the flash write status host: unlock addresses, commands, status bits, timing
`ifndef FWSR_MAP_VH
`define FWSR_MAP_VH

// Clock and timing
`define FWSR_CLK_NS 20
`define FWSR_TACC_NS 90
`define FWSR_TACC_CYC ((`FWSR_TACC_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_TWP_NS 35
`define FWSR_TWP_CYC ((`FWSR_TWP_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_TREC_CYC 2
`define FWSR_WIN_US 50
`define FWSR_WIN_CYC ((`FWSR_WIN_US * 1000) / `FWSR_CLK_NS)

// Status bit positions on the data lines
`define FWSR_POLLING_BIT 7
`define FWSR_FIRST_TOGGLE_BIT 6
`define FWSR_TIMEOUT_FAILURE_FLAG 5
`define FWSR_ERASE_WINDOW_FLAG 3
`define FWSR_SECOND_TOGGLE_BIT 2
`define FWSR_BUFFER_ABORT_FLAG 1

// User commands
`define FWSR_CMD_RAW 3'h0
`define FWSR_CMD_PROG 3'h1
`define FWSR_CMD_SECTOR 3'h2
`define FWSR_CMD_ADD 3'h3
`define FWSR_CMD_CHIP 3'h4
`define FWSR_CMD_WAIT 3'h5
`define FWSR_CMD_POLLBUF 3'h6
`define FWSR_CMD_RESET 3'h7
// Internal sequence kind for the buffer abort recovery sequence
`define FWSR_KIND_REC 4'h8

// Results
`define FWSR_RES_OK 2'h0
`define FWSR_RES_TIMEOUT 2'h1
`define FWSR_RES_ABORT 2'h2
`define FWSR_RES_REJECT 2'h3

// Flash command words and unlock addresses
`define FWSR_ADR_UNLOCK1 21'h000555
`define FWSR_ADR_UNLOCK2 21'h0002aa
`define FWSR_DAT_UNLOCK1 16'h00aa
`define FWSR_DAT_UNLOCK2 16'h0055
`define FWSR_DAT_PROG 16'h00a0
`define FWSR_DAT_ERASE 16'h0080
`define FWSR_DAT_SECTOR 16'h0030
`define FWSR_DAT_CHIP 16'h0010
`define FWSR_DAT_RESET 16'h00f0

`endif
